// *** core/tmcp_port.sv ***
// Mode control, signal meter, transmit path and configuration port
`timescale 1ns/100ps
module tmcp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    in_ready = (cnt_r != (PW+1)'(DEPTH));
    out_valid = (cnt_r != '0);
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  assign out_data = mem_r[rp_r];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; only entries below the count are read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule : tmcp_fifo

// Summary of operation
// - Meter disabled: powered down, analog output released
// - Status low nibble in-band, high nibble wideband
// - Shared converter, 16 periods, refresh every 32
// - Discharge 7 periods, then sample while high
// - Sample mode falling edge freezes result
// - Continuous mode keeps refreshing the status
// - Transmit: port deselected, master-out modulates
// - On-off keying: master-out gates output stage
// - Frequency keying: master-out picks the carrier
// - Transmit is one transparent state
// - Unlocked synthesizer forces output stage off
// - Standby: select high, wake low, ignore data
// - Detector enable chooses standby or detect
// - Standby exits only into configuration mode
// - Byte transfers, first byte is command
// - Command: count, start index, direction
// - Count field gives 1, 2, 4, 8
// - Index advances after each data byte
// - Byte taken on eighth falling edge
// - Entering configuration keeps register contents
// - Select low forces configuration state; from standby only while wake is high
module tmcp_port #(
  parameter int DIG_DIV = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic config_select_n,
  input wire logic wake,
  input wire logic port_select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic signal_meter_sample_ctrl,
  input wire logic pll_locked,
  input wire logic [3:0] if_level,
  input wire logic [3:0] lna_level,
  output logic peak_discharge_switch,
  output logic peak_sample_switch,
  output logic signal_meter_power,
  output logic signal_level_analog_out_oe_n,
  output logic rf_stage_on,
  output logic carrier_select,
  output logic standby_active,
  output logic lvd_active,
  output logic config_active,
  output logic cfg_fifo_ready
);
  localparam int DW = $clog2(DIG_DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIG_DIV - 1);

  // Two-stage synchronisers for every pin and analog comparator input
  logic [tmcp_pkg::SYNC_W-1:0] raw, s1_r, s2_r;
  assign raw = {lna_level, if_level, pll_locked, signal_meter_sample_ctrl, mosi, sclk,
                port_select_n, wake, config_select_n};
  for (genvar g = 0; g < tmcp_pkg::SYNC_W; g++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= raw[g];
        s2_r[g] <= s1_r[g];
      end
    end
  end

  logic cs_low, wake_s, sel_low, sclk_s, mosi_s, sctl_s, lock_s;
  logic [3:0] if_s, lna_s;
  always_comb begin
    cs_low = ~s2_r[tmcp_pkg::PIN_CS];
    wake_s = s2_r[tmcp_pkg::PIN_WAKE];
    sel_low = ~s2_r[tmcp_pkg::PIN_SEL];
    sclk_s = s2_r[tmcp_pkg::PIN_SCLK];
    mosi_s = s2_r[tmcp_pkg::PIN_MOSI];
    sctl_s = s2_r[tmcp_pkg::PIN_SCTL];
    lock_s = s2_r[tmcp_pkg::PIN_LOCK];
    if_s = s2_r[tmcp_pkg::PIN_IF_LSB +: 4];
    lna_s = s2_r[tmcp_pkg::PIN_LNA_LSB +: 4];
  end

  // Register file and control decode
  logic [7:0] regs_r [tmcp_pkg::REG_COUNT];
  logic [7:0] status_r, status_nxt, ctrl;
  logic meter_en_bit, cont_bit, mod_bit, lvd_bit, tx_bit;
  always_comb begin
    ctrl = regs_r[tmcp_pkg::CTRL_IDX];
    meter_en_bit = ctrl[tmcp_pkg::CTRL_METER_EN_BIT];
    cont_bit = ctrl[tmcp_pkg::CTRL_CONT_BIT];
    mod_bit = ctrl[tmcp_pkg::CTRL_MOD_BIT];
    lvd_bit = ctrl[tmcp_pkg::CTRL_LVD_BIT];
    tx_bit = ctrl[tmcp_pkg::CTRL_TX_BIT];
  end

  function automatic logic [7:0] rd_reg(input logic [4:0] i);
    rd_reg = (i == tmcp_pkg::STATUS_IDX) ? status_r : regs_r[i];
  endfunction : rd_reg

  // Mode control
  tmcp_pkg::tmcp_mode_type mode_r, mode_nxt;
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      tmcp_pkg::ST_STANDBY: begin
        if (cs_low && wake_s) begin
          mode_nxt = tmcp_pkg::ST_CONFIG;
        end
      end
      tmcp_pkg::ST_CONFIG: begin
        if (!cs_low) begin
          if (!wake_s) begin
            mode_nxt = tmcp_pkg::ST_STANDBY;
          end else if (tx_bit) begin
            mode_nxt = tmcp_pkg::ST_TX;
          end else begin
            mode_nxt = tmcp_pkg::ST_RX;
          end
        end
      end
      tmcp_pkg::ST_RX, tmcp_pkg::ST_TX: begin
        if (cs_low) begin
          mode_nxt = tmcp_pkg::ST_CONFIG;
        end else if (!wake_s) begin
          mode_nxt = tmcp_pkg::ST_STANDBY;
        end
      end
      default: mode_nxt = tmcp_pkg::ST_STANDBY;
    endcase
  end

  // Configuration port: serial slave, sample on falling clock edges
  logic sclk_q_r, sclk_q_nxt, fall;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_in_r, sh_in_nxt, sh_out_r, sh_out_nxt, byte_in;
  logic have_cmd_r, have_cmd_nxt, wr_r, wr_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [3:0] left_r, left_nxt;
  logic port_on, push, rd_load;
  logic [tmcp_pkg::FIFO_WIDTH-1:0] push_data, drain_data;
  logic drain_valid, drain_ready;

  always_comb begin
    port_on = (mode_r == tmcp_pkg::ST_CONFIG) && cs_low && sel_low;
    fall = sclk_q_r & ~sclk_s;
    byte_in = {sh_in_r[6:0], mosi_s};
    sclk_q_nxt = sclk_s;
    bit_nxt = bit_r;
    sh_in_nxt = sh_in_r;
    sh_out_nxt = sh_out_r;
    have_cmd_nxt = have_cmd_r;
    wr_nxt = wr_r;
    idx_nxt = idx_r;
    left_nxt = left_r;
    push = 1'b0;
    rd_load = 1'b0;
    push_data = {idx_r, byte_in};
    if (!port_on) begin
      // A partial byte dies with the select edge
      bit_nxt = '0;
      have_cmd_nxt = 1'b0;
      left_nxt = '0;
      sh_out_nxt = '0;
    end else if (fall) begin
      sh_in_nxt = byte_in;
      bit_nxt = bit_r + 3'h1;
      sh_out_nxt = {sh_out_r[6:0], 1'b0};
      if (bit_r == tmcp_pkg::LAST_BIT) begin
        if (!have_cmd_r) begin
          have_cmd_nxt = 1'b1;
          wr_nxt = byte_in[tmcp_pkg::CMD_RW_BIT];
          idx_nxt = byte_in[tmcp_pkg::CMD_A_MSB:tmcp_pkg::CMD_A_LSB];
          left_nxt = 4'h1 << byte_in[tmcp_pkg::CMD_N_MSB:tmcp_pkg::CMD_N_LSB];
          if (!byte_in[tmcp_pkg::CMD_RW_BIT]) begin
            sh_out_nxt = rd_reg(idx_nxt);
            rd_load = 1'b1;
          end
        end else if (left_r != '0) begin
          push = wr_r;
          left_nxt = left_r - 4'h1;
          idx_nxt = idx_r + 5'h01;
          if (!wr_r && left_r != 4'h1) begin
            sh_out_nxt = rd_reg(idx_nxt);
            rd_load = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_q_r <= 1'b0;
      bit_r <= '0;
      sh_in_r <= '0;
      sh_out_r <= '0;
      have_cmd_r <= 1'b0;
      wr_r <= 1'b0;
      idx_r <= '0;
      left_r <= '0;
    end else begin
      sclk_q_r <= sclk_q_nxt;
      bit_r <= bit_nxt;
      sh_in_r <= sh_in_nxt;
      sh_out_r <= sh_out_nxt;
      have_cmd_r <= have_cmd_nxt;
      wr_r <= wr_nxt;
      idx_r <= idx_nxt;
      left_r <= left_nxt;
    end
  end

  // Written bytes queue here; a full queue drops the byte and shows it
  tmcp_fifo #(
    .WIDTH(tmcp_pkg::FIFO_WIDTH),
    .DEPTH(tmcp_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(cfg_fifo_ready),
    .in_data(push_data),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_data)
  );

  // Drain yields to a register read load so both never land together
  assign drain_ready = ~rd_load;

  // Contents change only by written bytes, never by a mode change
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < tmcp_pkg::REG_COUNT; i++) begin
        regs_r[i] <= tmcp_pkg::REG_RESET;
      end
    end else if (drain_valid && drain_ready &&
                 drain_data[12:8] != tmcp_pkg::STATUS_IDX) begin
      regs_r[drain_data[12:8]] <= drain_data[7:0];
    end
  end

  // Signal meter
  logic meter_on;
  logic [DW-1:0] div_r, div_nxt;
  logic tick;
  logic [4:0] phase_r, phase_nxt;
  logic [2:0] dcnt_r, dcnt_nxt;
  logic disch_r, disch_nxt, samp_r, samp_nxt, frozen_r, frozen_nxt, sctl_q_r, sctl_q_nxt;
  always_comb begin
    meter_on = meter_en_bit && (mode_r == tmcp_pkg::ST_RX);
    tick = (div_r == DIV_LAST);
    div_nxt = tick ? '0 : div_r + DW'(1);
    phase_nxt = phase_r;
    dcnt_nxt = dcnt_r;
    disch_nxt = disch_r;
    frozen_nxt = frozen_r;
    status_nxt = status_r;
    sctl_q_nxt = sctl_s;
    if (!meter_on) begin
      // Meter held idle while disabled; only the period divider keeps running
      phase_nxt = '0;
      dcnt_nxt = '0;
      disch_nxt = 1'b0;
      frozen_nxt = 1'b0;
      sctl_q_nxt = 1'b0;
    end else begin
      if (sctl_s && !sctl_q_r) begin
        disch_nxt = 1'b1;
        dcnt_nxt = '0;
        frozen_nxt = 1'b0;
      end else if (tick && disch_r) begin
        dcnt_nxt = dcnt_r + 3'h1;
        if (dcnt_r == tmcp_pkg::DISCH_LAST) begin
          disch_nxt = 1'b0;
        end
      end
      if (!sctl_s && sctl_q_r && !cont_bit) begin
        frozen_nxt = 1'b1;
      end
      // The host keeps the pulse long enough for one refresh
      if (tick && (!frozen_r || cont_bit)) begin
        phase_nxt = phase_r + 5'h01;
        if (phase_r == tmcp_pkg::CONV_LAST) begin
          status_nxt[3:0] = if_s;
        end
        if (phase_r == tmcp_pkg::UPD_LAST) begin
          status_nxt[7:4] = lna_s;
        end
      end
    end
    samp_nxt = meter_on && sctl_s && !disch_nxt && !(frozen_nxt && !cont_bit);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= '0;
      phase_r <= '0;
      dcnt_r <= '0;
      disch_r <= 1'b0;
      samp_r <= 1'b0;
      frozen_r <= 1'b0;
      sctl_q_r <= 1'b0;
      status_r <= tmcp_pkg::STATUS_RESET;
    end else begin
      div_r <= div_nxt;
      phase_r <= phase_nxt;
      dcnt_r <= dcnt_nxt;
      disch_r <= disch_nxt;
      samp_r <= samp_nxt;
      frozen_r <= frozen_nxt;
      sctl_q_r <= sctl_q_nxt;
      status_r <= status_nxt;
    end
  end

  // Transmit path and mode outputs
  logic rf_r, rf_nxt, car_r, car_nxt, meter_pwr_r;
  logic stby_r, stby_nxt, lvd_r, lvd_nxt, cfg_r, cfg_nxt, oe_r, oe_nxt;
  always_comb begin
    rf_nxt = 1'b0;
    car_nxt = 1'b0;
    if (mode_nxt == tmcp_pkg::ST_TX && lock_s) begin
      rf_nxt = mod_bit ? 1'b1 : mosi_s;
      car_nxt = mod_bit & mosi_s;
    end
    stby_nxt = (mode_nxt == tmcp_pkg::ST_STANDBY) && !lvd_bit;
    lvd_nxt = (mode_nxt == tmcp_pkg::ST_STANDBY) && lvd_bit;
    cfg_nxt = (mode_nxt == tmcp_pkg::ST_CONFIG);
    oe_nxt = port_on && have_cmd_nxt && !wr_nxt && (left_nxt != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r <= tmcp_pkg::ST_STANDBY;
      rf_r <= 1'b0;
      car_r <= 1'b0;
      meter_pwr_r <= 1'b0;
      stby_r <= 1'b1;
      lvd_r <= 1'b0;
      cfg_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      rf_r <= rf_nxt;
      car_r <= car_nxt;
      meter_pwr_r <= meter_on;
      stby_r <= stby_nxt;
      lvd_r <= lvd_nxt;
      cfg_r <= cfg_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign miso_o = sh_out_r[7];
  assign miso_oe_n = ~oe_r;
  assign peak_discharge_switch = disch_r;
  assign peak_sample_switch = samp_r;
  assign signal_meter_power = meter_pwr_r;
  assign signal_level_analog_out_oe_n = ~meter_pwr_r;
  assign rf_stage_on = rf_r;
  assign carrier_select = car_r;
  assign standby_active = stby_r;
  assign lvd_active = lvd_r;
  assign config_active = cfg_r;
endmodule : tmcp_port

// *** include/tmcp_pkg.sv ***
// Shared constants and types for the transceiver mode and configuration port
package tmcp_pkg;
  // Register file geometry and the register index map
  localparam int REG_COUNT = 32;
  localparam int IDX_W = 5;
  localparam logic [4:0] CTRL_IDX = 5'h00;
  localparam logic [4:0] STATUS_IDX = 5'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Control register fields
  localparam int CTRL_METER_EN_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_MOD_BIT = 2;
  localparam int CTRL_LVD_BIT = 3;
  localparam int CTRL_TX_BIT = 4;
  // Command byte fields
  localparam int CMD_N_MSB = 7;
  localparam int CMD_N_LSB = 6;
  localparam int CMD_A_MSB = 5;
  localparam int CMD_A_LSB = 1;
  localparam int CMD_RW_BIT = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Signal meter timing, in digital clock periods
  localparam int DISCHARGE_PERIODS = 7;
  localparam int CONV_PERIODS = 16;
  localparam int UPDATE_PERIODS = 32;
  localparam logic [2:0] DISCH_LAST = 3'(DISCHARGE_PERIODS - 1);
  localparam logic [4:0] CONV_LAST = 5'(CONV_PERIODS - 1);
  localparam logic [4:0] UPD_LAST = 5'(UPDATE_PERIODS - 1);
  // Documented state numbers
  localparam int STATE_NUM_CONFIG = 1;
  localparam int STATE_NUM_TX = 30;
  localparam int STATE_NUM_STANDBY = 60;
  // Synchroniser lanes
  localparam int SYNC_W = 15;
  localparam int PIN_CS = 0;
  localparam int PIN_WAKE = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_SCLK = 3;
  localparam int PIN_MOSI = 4;
  localparam int PIN_SCTL = 5;
  localparam int PIN_LOCK = 6;
  localparam int PIN_IF_LSB = 7;
  localparam int PIN_LNA_LSB = 11;
  // Write FIFO
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 13;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_CONFIG = 2'b01,
    ST_RX = 2'b11,
    ST_TX = 2'b10
  } tmcp_mode_type;
endpackage : tmcp_pkg

// *** verification/tmcp_port_assertions.sv ***
// Pin level checks for the port block
`timescale 1ns/100ps
module tmcp_port_assertions #(
  parameter int DIG_DIV = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic config_select_n,
  input wire logic wake,
  input wire logic pll_locked,
  input wire logic miso_oe_n,
  input wire logic peak_discharge_switch,
  input wire logic peak_sample_switch,
  input wire logic signal_meter_power,
  input wire logic signal_level_analog_out_oe_n,
  input wire logic rf_stage_on,
  input wire logic carrier_select,
  input wire logic standby_active,
  input wire logic config_active
);
  logic [7:0] disch_cnt_r;
  logic [7:0] disch_cnt_nxt;
  always_comb begin
    disch_cnt_nxt = peak_discharge_switch ? disch_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge sys_clk) begin
    disch_cnt_r <= rst ? 8'h00 : disch_cnt_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Powered-down meter also leaves both switches open
  property p_meter_off;
    (signal_level_analog_out_oe_n == !signal_meter_power) &&
      (signal_meter_power || (!peak_discharge_switch && !peak_sample_switch));
  endproperty
  a_meter_off: assert property (p_meter_off)
    else $error("analog buffer on while meter off");
  // Period phase at the start may cost up to one period; power-off cuts it short
  property p_disch_len;
    $fell(peak_discharge_switch) && signal_meter_power |->
      disch_cnt_r > 8'(6 * DIG_DIV) && disch_cnt_r <= 8'(7 * DIG_DIV + 1);
  endproperty
  a_disch_len: assert property (p_disch_len)
    else $error("discharge length wrong");
  property p_no_samp;
    peak_discharge_switch |-> !peak_sample_switch;
  endproperty
  a_no_samp: assert property (p_no_samp)
    else $error("sample closed while discharging");
  property p_tx_lock;
    (!pll_locked) [*5] |-> !rf_stage_on;
  endproperty
  a_tx_lock: assert property (p_tx_lock)
    else $error("output stage on while unlocked");
  property p_fsk;
    carrier_select |-> rf_stage_on;
  endproperty
  a_fsk: assert property (p_fsk)
    else $error("carrier one with stage off");
  property p_cfg_entry;
    (!config_select_n && wake) [*6] |=> config_active;
  endproperty
  a_cfg_entry: assert property (p_cfg_entry)
    else $error("configuration not entered");
  property p_miso_quiet;
    !config_active && !$past(config_active) |-> miso_oe_n;
  endproperty
  a_miso_quiet: assert property (p_miso_quiet)
    else $error("serial output driven outside configuration");
  property p_standby;
    standby_active && $past(standby_active) |-> !rf_stage_on && miso_oe_n;
  endproperty
  a_standby: assert property (p_standby)
    else $error("activity in standby");
endmodule : tmcp_port_assertions

bind tmcp_port tmcp_port_assertions #(.DIG_DIV(DIG_DIV)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .config_select_n(config_select_n), .wake(wake),
  .pll_locked(pll_locked), .miso_oe_n(miso_oe_n),
  .peak_discharge_switch(peak_discharge_switch), .peak_sample_switch(peak_sample_switch),
  .signal_meter_power(signal_meter_power),
  .signal_level_analog_out_oe_n(signal_level_analog_out_oe_n),
  .rf_stage_on(rf_stage_on), .carrier_select(carrier_select),
  .standby_active(standby_active), .config_active(config_active)
);

// *** verification/tmcp_host.sv ***
// Host side model: mode pins and serial master
`timescale 1ns/100ps
module tmcp_host (
  input wire logic sys_clk,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  output logic config_select_n,
  output logic wake,
  output logic port_select_n,
  output logic sclk,
  output logic mosi
);
  logic miso_last_r;
  logic miso_line;
  logic [7:0] data_q [9];
  // Released line shows the inverse of its last level
  always @(posedge sys_clk) begin
    if (!miso_oe_n) begin
      miso_last_r <= miso_o;
    end
  end
  assign miso_line = miso_oe_n ? !miso_last_r : miso_o;
  initial begin
    miso_last_r = 1'b0;
    config_select_n = 1'b1;
    wake = 1'b0;
    port_select_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task pins(input logic cs, input logic wk, input logic m);
    @(negedge sys_clk);
    config_select_n = cs;
    wake = wk;
    port_select_n = cs;
    mosi = m;
    repeat (8) @(negedge sys_clk);
  endtask : pins
  // Data moves mid-way through the low phase so it never rides the sampling fall
  task shift(input int bits, inout logic [7:0] d);
    for (int i = 0; i < bits; i++) begin
      #16 mosi = d[7];
      #16 sclk = 1'b1;
      d = {d[6:0], miso_line};
      #32 sclk = 1'b0;
    end
  endtask : shift
  task burst(input logic [7:0] cmd, input int n, input int tail);
    logic [7:0] c;
    c = cmd;
    pins(1'b0, 1'b1, 1'b0);
    for (int i = -1; i < n; i++) begin
      if (i < 0) begin
        shift(8, c);
      end else begin
        shift(8, data_q[i]);
      end
    end
    if (tail > 0) begin
      shift(tail, data_q[n]);
    end
    #32;
    pins(1'b1, 1'b1, 1'b0);
  endtask : burst
endmodule : tmcp_host

// *** verification/test_transceiver_mode_and_config_port.sv ***
// Self-checking bench for the port block
`timescale 1ns/100ps
module test_transceiver_mode_and_config_port;
  localparam logic [7:0] RD_EXP [8] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'h5C, 8'h00, 8'h00, 8'h00};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic signal_meter_sample_ctrl = 1'b0;
  logic pll_locked = 1'b1;
  logic [3:0] if_level = 4'h5;
  logic [3:0] lna_level = 4'hA;
  wire logic config_select_n, wake, port_select_n, sclk, mosi, miso_o, miso_oe_n;
  wire logic peak_discharge_switch, peak_sample_switch, signal_meter_power;
  wire logic signal_level_analog_out_oe_n, rf_stage_on, carrier_select;
  wire logic standby_active, lvd_active, config_active, cfg_fifo_ready;
  logic [7:0] flags;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  assign flags = {miso_oe_n, signal_level_analog_out_oe_n, signal_meter_power, standby_active,
    lvd_active, config_active, rf_stage_on, carrier_select};
  always #2.5 sys_clk = !sys_clk;
  tmcp_port #(.DIG_DIV(2)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .config_select_n(config_select_n), .wake(wake),
    .port_select_n(port_select_n), .sclk(sclk), .mosi(mosi), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .signal_meter_sample_ctrl(signal_meter_sample_ctrl),
    .pll_locked(pll_locked), .if_level(if_level), .lna_level(lna_level),
    .peak_discharge_switch(peak_discharge_switch), .peak_sample_switch(peak_sample_switch),
    .signal_meter_power(signal_meter_power),
    .signal_level_analog_out_oe_n(signal_level_analog_out_oe_n),
    .rf_stage_on(rf_stage_on), .carrier_select(carrier_select),
    .standby_active(standby_active), .lvd_active(lvd_active),
    .config_active(config_active), .cfg_fifo_ready(cfg_fifo_ready)
  );
  tmcp_host host_u (
    .sys_clk(sys_clk), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .config_select_n(config_select_n), .wake(wake), .port_select_n(port_select_n),
    .sclk(sclk), .mosi(mosi)
  );
  task final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check
  task wait_clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_clk
  task wr_ctrl(input logic [7:0] v);
    host_u.data_q[0] = v;
    host_u.burst(8'h01, 1, 0);
  endtask : wr_ctrl
  task rd_status(input logic [7:0] want);
    host_u.burst(8'h02, 1, 0);
    check(host_u.data_q[0], want);
  endtask : rd_status
  task t_modes();
    check(flags, 8'hD0);
    host_u.pins(1'b1, 1'b1, 1'b0);
    check(flags, 8'hD0);
    host_u.pins(1'b0, 1'b1, 1'b0);
    check(flags, 8'hC4);
    host_u.pins(1'b1, 1'b0, 1'b1);
    check(flags, 8'hD0);
  endtask : t_modes
  task t_regs();
    for (int i = 0; i < 4; i++) begin
      host_u.data_q[i] = {4'hA, 4'(i)};
    end
    host_u.burst(8'h85, 4, 0);
    host_u.data_q[0] = 8'h5C;
    host_u.data_q[1] = 8'h77;
    host_u.burst(8'h0D, 2, 0);
    host_u.data_q[0] = 8'hFF;
    host_u.burst(8'h11, 0, 5);
    host_u.data_q[0] = 8'hFF;
    host_u.burst(8'h03, 1, 0);
    check(8'(cfg_fifo_ready), 8'h01);
    host_u.burst(8'hC4, 8, 0);
    for (int i = 0; i < 8; i++) begin
      check(host_u.data_q[i], RD_EXP[i]);
    end
    host_u.burst(8'h40, 2, 0);
    check(host_u.data_q[0], 8'h00);
    check(host_u.data_q[1], 8'h00);
  endtask : t_regs
  task t_meter();
    wr_ctrl(8'h01);
    check(flags, 8'hA0);
    signal_meter_sample_ctrl = 1'b1;
    wait_clk(8);
    check(8'({peak_discharge_switch, peak_sample_switch}), 8'h02);
    wait_clk(22);
    check(8'({peak_discharge_switch, peak_sample_switch}), 8'h01);
    wait_clk(80);
    signal_meter_sample_ctrl = 1'b0;
    wait_clk(10);
    if_level = 4'h3;
    lna_level = 4'hC;
    wait_clk(140);
    check(8'(peak_sample_switch), 8'h00);
    rd_status(8'hA5);
    wr_ctrl(8'h03);
    signal_meter_sample_ctrl = 1'b1;
    wait_clk(80);
    signal_meter_sample_ctrl = 1'b0;
    wait_clk(10);
    if_level = 4'h6;
    lna_level = 4'h9;
    wait_clk(140);
    rd_status(8'h96);
    wr_ctrl(8'h00);
    check(flags, 8'hC0);
  endtask : t_meter
  task t_tx();
    logic rf;
    logic car;
    for (int k = 0; k < 8; k++) begin
      rf = k[0] & (k[2] | k[1]);
      car = k[0] & k[2] & k[1];
      wr_ctrl({5'h02, k[2], 2'h0});
      pll_locked = k[0];
      host_u.pins(1'b1, 1'b1, k[1]);
      check(flags, {6'h30, rf, car});
    end
    pll_locked = 1'b1;
  endtask : t_tx
  task t_standby();
    wr_ctrl(8'h08);
    host_u.pins(1'b1, 1'b0, 1'b0);
    check(flags, 8'hC8);
    host_u.pins(1'b1, 1'b1, 1'b1);
    check(flags, 8'hC8);
    wr_ctrl(8'h00);
    host_u.pins(1'b1, 1'b0, 1'b1);
    check(flags, 8'hD0);
  endtask : t_standby
  // Whole run is near 7k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    wait_clk(4);
    t_modes();
    t_regs();
    t_meter();
    t_tx();
    t_standby();
    final_report();
  end
endmodule : test_transceiver_mode_and_config_port
